// ---- inc/csm_pkg.sv ----
// package: constants, carriers and state of the configurable spi engine
// assumes a single 250 MHz ref_clk and a synchronous active-low reset
package csm_pkg;

  localparam int unsigned CLK_PERIOD_PS  = 4000;
  localparam int unsigned US_PS          = 1000000;
  localparam int unsigned CYC_PER_US     = US_PS / CLK_PERIOD_PS;
  localparam int unsigned WORD_BITS      = 8;
  localparam int unsigned TX_FIFO_DEPTH  = 16;
  localparam int unsigned TMR_W          = 20;

  localparam logic [3:0]       EDGE_LAST    = 4'hF;
  localparam logic [4:0]       EDGES_WORD   = 5'h10;
  localparam logic [1:0]       DEFAULT_MODE = 2'h1;
  // sclk half periods in ref_clk cycles for divide by 4, 16, 64, 128
  localparam logic [TMR_W-1:0] HALF_DIV4    = 20'h00002;
  localparam logic [TMR_W-1:0] HALF_DIV16   = 20'h00008;
  localparam logic [TMR_W-1:0] HALF_DIV64   = 20'h00020;
  localparam logic [TMR_W-1:0] HALF_DIV128  = 20'h00040;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_RUN   = 4'h2,
    ST_DONE  = 4'h4,
    ST_SLAVE = 4'h8
  } csm_state_t;

  typedef struct packed {
    logic       bit_driven_variant;
    logic       fixed_defaults;
    logic       master_en;
    logic       polarity;
    logic       clock_phase;
    logic       mode_valid;
    logic [1:0] mode;
    logic       lsb_first;
    logic [1:0] clock_divider_setting;
    logic       ss_none;
    logic       select_suppress;
    logic       irq_en;
    logic [7:0] read_fill_value;
    logic [7:0] speed_us;
    logic [7:0] setup_us;
  } csm_cfg_t;

  typedef struct packed {
    logic       read_only;
    logic [7:0] data;
  } csm_txw_t;

  typedef struct packed {
    csm_state_t st;
    logic [3:0] edge_cnt;
    logic [7:0] tx;
    logic [7:0] rx;
    logic       sclk;
    logic       ss_n;
    logic [7:0] rx_data;
    logic       rx_valid;
    logic       irq;
    logic       sclk_prev;
    logic       ss_prev;
    logic [2:0] scnt;
  } csm_core_t;

  localparam csm_core_t CORE_RST = '{
    st: ST_IDLE, edge_cnt: 4'h0, tx: 8'h00, rx: 8'h00, sclk: 1'b0,
    ss_n: 1'b1, rx_data: 8'h00, rx_valid: 1'b0, irq: 1'b0,
    sclk_prev: 1'b0, ss_prev: 1'b1, scnt: 3'h0};

endpackage

// ---- src/csm_timer.sv ----
// file: down counter timing one sclk half period
// assumes load only when idle or in the cycle that done is high
`timescale 1ns/1ps
module csm_timer
  import csm_pkg::*;
#(
  parameter int unsigned W = TMR_W
)(
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  input  wire logic         load,
  input  wire logic [W-1:0] value,
  output logic              done
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  always_comb
  begin
    cnt_d = cnt_q;
    if (load)
      cnt_d = value;
    else if (cnt_q != '0)
      cnt_d = cnt_q - 1'b1;
  end

  // done fires value cycles after load
  // no load term: the reload in the done cycle would loop back on done
  assign done = (cnt_q == {{(W-1){1'b0}}, 1'b1});

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      cnt_q <= '0;
    else
      cnt_q <= cnt_d;
  end

endmodule // csm_timer

// ---- src/csm_fifo.sv ----
// file: flop based word fifo on the transmit path
// assumes depth is a power of two
`timescale 1ns/1ps
module csm_fifo
  import csm_pkg::*;
#(
  parameter int unsigned WIDTH = $bits(csm_txw_t),
  parameter int unsigned DEPTH = TX_FIFO_DEPTH
)(
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int unsigned AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0]                 wr;
    logic [AW:0]                 rd;
  } csm_fifo_st_t;

  csm_fifo_st_t q;
  csm_fifo_st_t d;
  logic         push;
  logic         pull;

  // extra pointer bit tells full from empty
  assign in_ready  = (q.wr[AW-1:0] != q.rd[AW-1:0]) ||
                     (q.wr[AW] == q.rd[AW]);
  assign out_valid = (q.wr != q.rd);
  assign out_data  = q.mem[q.rd[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pull      = out_valid && out_ready;

  always_comb
  begin
    d = q;
    if (push)
    begin
      d.mem[q.wr[AW-1:0]] = in_data;
      d.wr = q.wr + 1'b1;
    end
    if (pull)
      d.rd = q.rd + 1'b1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      q <= '0;
    else
      q <= d;
  end

endmodule // csm_fifo

// ---- src/csm_spi_engine.sv ----
// file: configurable spi transfer engine, master or slave, 8 bit words
// assumes pins synchronous to ref_clk; pin buffers outside use the oe_n
// Functional notes
// - bit driven variant runs as master only, never slave
// - select set to none: no select output is generated
// - select suppress high stops select output, low generates it
// - bit order setting picks msb or lsb first, both directions
// - fixed pin variant role setting picks master or slave
// - polarity sets idle level of the serial clock
// - master clock is ref clock divided by 4, 16, 64 or 128
// - interrupt option gates the transfer interrupt output
// - read only words send the fill byte, default zero
// - bit driven mode 0 to 3, mode 1 when none given
// - four clock modes fix which edges sample and set up
// - speed N sets each sclk half period to N us
// - setup value delays sampling of the data input
// - speed and setup only apply with an explicit mode
// - generated select goes low for transfer, high after
// - fixed pin variant alone: slave, polarity 0, phase 0
`timescale 1ns/1ps
module csm_spi_engine
  import csm_pkg::*;
#(
  parameter int unsigned FIFO_DEPTH = TX_FIFO_DEPTH
)(
  input  wire logic     ref_clk,
  input  wire logic     rst_n,
  input  wire csm_cfg_t cfg,
  input  wire logic     tx_valid,
  output logic          tx_ready,
  input  wire csm_txw_t tx_word,
  output logic [7:0]    rx_data,
  output logic          rx_valid,
  output logic          xfer_irq,
  output logic          busy,
  output logic          sclk_o,
  output logic          sclk_oe_n,
  input  wire logic     sclk_i,
  output logic          mosi_o,
  output logic          mosi_oe_n,
  input  wire logic     mosi_i,
  output logic          miso_o,
  output logic          miso_oe_n,
  input  wire logic     miso_i,
  output logic          ss_n_o,
  output logic          ss_oe_n,
  input  wire logic     ss_n_i
);

  csm_core_t        q;
  csm_core_t        d;
  csm_txw_t         fifo_word;
  logic             fifo_valid;
  logic             pop;
  logic             tmr_load;
  logic             tmr_done;
  logic [TMR_W-1:0] tmr_val;
  logic [TMR_W-1:0] half_cnt;
  logic [TMR_W-1:0] setup_cnt;
  logic [1:0]       eff_mode;
  logic             eff_master;
  logic             eff_cpol;
  logic             eff_cpha;
  logic             eff_lsb;
  logic             eff_ss;
  logic             eff_irq;
  logic             timed;
  logic             tx_bit;
  logic             sin;
  logic [7:0]       rx_shift;
  logic [7:0]       tx_shift;
  logic [7:0]       load_byte;
  logic [7:0]       slave_byte;
  logic             slv_lead;
  logic             slv_trail;
  logic             s_sample;
  logic             s_shift;
  logic             m_sample;
  logic             start;
  logic [4:0]       tog_q;

  csm_fifo #(
    .WIDTH ($bits(csm_txw_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .in_data   (tx_word),
    .out_valid (fifo_valid),
    .out_ready (pop),
    .out_data  (fifo_word)
  );

  csm_timer #(
    .W (TMR_W)
  ) u_timer (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .load    (tmr_load),
    .value   (tmr_val),
    .done    (tmr_done)
  );

  // effective settings per variant
  always_comb
  begin
    eff_mode = cfg.mode_valid ? cfg.mode : DEFAULT_MODE;
    if (cfg.bit_driven_variant)
    begin
      eff_master = 1'b1;
      eff_cpol   = eff_mode[1];
      eff_cpha   = eff_mode[0];
      eff_ss     = !cfg.ss_none;
    end
    else if (cfg.fixed_defaults)
    begin
      eff_master = 1'b0;
      eff_cpol   = 1'b0;
      eff_cpha   = 1'b0;
      eff_ss     = 1'b0;
    end
    else
    begin
      eff_master = cfg.master_en;
      eff_cpol   = cfg.polarity;
      eff_cpha   = cfg.clock_phase;
      eff_ss     = !cfg.select_suppress;
    end
    eff_lsb = cfg.lsb_first &&
              (cfg.bit_driven_variant || !cfg.fixed_defaults);
    eff_irq = cfg.irq_en &&
              (cfg.bit_driven_variant || !cfg.fixed_defaults);
    timed   = cfg.bit_driven_variant && cfg.mode_valid;
  end

  // sclk half period; long waits are fine, the timer is 20 bits wide
  always_comb
  begin
    case (cfg.clock_divider_setting)
      2'h0:    half_cnt = HALF_DIV4;
      2'h1:    half_cnt = HALF_DIV16;
      2'h2:    half_cnt = HALF_DIV64;
      default: half_cnt = HALF_DIV128;
    endcase
    if (timed && cfg.speed_us != 8'h00)
      half_cnt = TMR_W'(cfg.speed_us) * TMR_W'(CYC_PER_US);
    setup_cnt = timed ? TMR_W'(cfg.setup_us) * TMR_W'(CYC_PER_US)
                      : '0;
  end

  // shift paths shared by master and slave
  assign tx_bit     = eff_lsb ? q.tx[0] : q.tx[7];
  assign sin        = eff_master ? miso_i : mosi_i;
  assign rx_shift   = eff_lsb ? {sin, q.rx[7:1]}
                              : {q.rx[6:0], sin};
  assign tx_shift   = eff_lsb ? {1'b0, q.tx[7:1]} : {q.tx[6:0], 1'b0};
  assign load_byte  = fifo_word.read_only ? cfg.read_fill_value
                                          : fifo_word.data;
  assign slave_byte = fifo_valid ? load_byte : cfg.read_fill_value;
  assign start      = (q.st == ST_IDLE) && eff_master && fifo_valid;

  always_comb
  begin
    d           = q;
    d.rx_valid  = 1'b0;
    d.irq       = 1'b0;
    d.sclk_prev = sclk_i;
    d.ss_prev   = ss_n_i;
    pop         = 1'b0;
    tmr_load    = 1'b0;
    tmr_val     = half_cnt;
    // even edge numbers are leading edges
    m_sample  = !q.edge_cnt[0] ^ eff_cpha;
    slv_lead  = (q.sclk_prev == eff_cpol) && (sclk_i != eff_cpol);
    slv_trail = (q.sclk_prev != eff_cpol) && (sclk_i == eff_cpol);
    s_sample  = eff_cpha ? slv_trail : slv_lead;
    // no shift before the first sample: the first bit is preloaded
    s_shift   = (eff_cpha ? slv_lead : slv_trail) && (q.scnt != 3'h0);
    case (q.st)
      ST_IDLE:
      begin
        d.sclk = eff_cpol;
        d.ss_n = 1'b1;
        if (!eff_master)
          d.st = ST_SLAVE;
        else if (fifo_valid)
        begin
          pop        = 1'b1;
          d.tx       = load_byte;
          d.rx       = 8'h00;
          d.edge_cnt = 4'h0;
          d.ss_n     = !eff_ss;
          tmr_load   = 1'b1;
          tmr_val    = half_cnt + (eff_cpha ? '0 : setup_cnt);
          d.st       = ST_RUN;
        end
      end
      ST_RUN:
      begin
        if (tmr_done)
        begin
          d.sclk = !q.sclk;
          if (m_sample)
            d.rx = rx_shift;
          else if (q.edge_cnt != 4'h0)
            d.tx = tx_shift;
          if (q.edge_cnt == EDGE_LAST)
            d.st = ST_DONE;
          else
          begin
            d.edge_cnt = q.edge_cnt + 4'h1;
            tmr_load   = 1'b1;
            tmr_val    = half_cnt +
                         ((q.edge_cnt[0] ^ eff_cpha) ? setup_cnt
                                                     : '0);
          end
        end
      end
      ST_DONE:
      begin
        d.rx_data  = q.rx;
        d.rx_valid = 1'b1;
        d.irq      = eff_irq;
        d.ss_n     = 1'b1;
        d.st       = ST_IDLE;
      end
      ST_SLAVE:
      begin
        d.sclk = eff_cpol;
        d.ss_n = 1'b1;
        if (eff_master)
          d.st = ST_IDLE;
        else if (ss_n_i)
          d.scnt = 3'h0;
        else if (q.ss_prev)
        begin
          // an edge in the select cycle is lost; masters leave a gap
          pop  = fifo_valid;
          d.tx = slave_byte;
          d.rx = 8'h00;
        end
        else if (s_sample)
        begin
          d.rx   = rx_shift;
          d.scnt = q.scnt + 3'h1;
          if (q.scnt == 3'h7)
          begin
            d.rx_data  = rx_shift;
            d.rx_valid = 1'b1;
            d.irq      = eff_irq;
            pop        = fifo_valid;
            d.tx       = slave_byte;
          end
        end
        else if (s_shift)
          d.tx = tx_shift;
      end
      default:
        d = CORE_RST;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      q <= CORE_RST;
    else
      q <= d;
  end

  // sclk edges in the current master word, read by checks only
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n || q.st == ST_IDLE)
      tog_q <= 5'h00;
    else if (q.st == ST_RUN && tmr_done)
      tog_q <= tog_q + 5'h01;
  end

  assign sclk_o    = q.sclk;
  assign sclk_oe_n = !eff_master;
  assign mosi_o    = tx_bit;
  assign mosi_oe_n = !eff_master;
  assign miso_o    = tx_bit;
  assign miso_oe_n = eff_master || ss_n_i;
  assign ss_n_o    = q.ss_n;
  assign ss_oe_n   = !(eff_master && eff_ss);
  assign rx_data   = q.rx_data;
  assign rx_valid  = q.rx_valid;
  assign xfer_irq  = q.irq;
  assign busy      = (q.st == ST_RUN) || (q.st == ST_DONE);

  bitdrv_master_only_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    cfg.bit_driven_variant [*2] |-> q.st != ST_SLAVE && !sclk_oe_n)
    else $error("bit driven variant left master role");

  ss_none_quiet_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    cfg.bit_driven_variant && cfg.ss_none |-> ss_oe_n)
    else $error("select driven although set to none");

  ss_suppress_quiet_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    !cfg.bit_driven_variant && cfg.select_suppress |-> ss_oe_n)
    else $error("select driven although suppressed");

  idle_clock_level_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    q.st == ST_IDLE && !start |=> sclk_o == $past(eff_cpol))
    else $error("idle clock level differs from polarity");

  div_four_half_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    tmr_load && tmr_val == HALF_DIV4 |-> ##1 !tmr_done ##1 tmr_done)
    else $error("divide by four half period is not two cycles");

  irq_gate_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    xfer_irq |-> $past(eff_irq) && rx_valid)
    else $error("interrupt raised while disabled");

  fill_byte_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    start && fifo_word.read_only |=> q.tx == $past(cfg.read_fill_value))
    else $error("read only word did not load the fill byte");

  default_mode_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    cfg.bit_driven_variant && !cfg.mode_valid |-> !eff_cpol && eff_cpha)
    else $error("missing mode did not fall back to mode 1");

  speed_half_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    timed && cfg.speed_us == 8'h01 |-> half_cnt == 20'h000FA)
    else $error("speed of one us is not 250 cycles per half");

  untimed_no_setup_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    !cfg.mode_valid |-> setup_cnt == '0 && half_cnt <= HALF_DIV128)
    else $error("delay applied without an explicit mode");

  ss_frame_low_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    start && eff_ss |=> (!ss_n_o) [*8])
    else $error("select not held low at transfer start");

  edges_per_word_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    q.st == ST_DONE |-> tog_q == EDGES_WORD ##1 rx_valid)
    else $error("master word did not take sixteen clock edges");

endmodule // csm_spi_engine

// ---- dv/csm_slave_model.sv ----
// file: behavioural serial slave facing the engine's master link
// assumes active-low select and a mode that stays put while selected
`timescale 1ns/1ps
module csm_slave_model
  import csm_pkg::*;
(
  input  wire logic       sclk,
  input  wire logic       ss_n,
  input  wire logic       mosi,
  output logic            miso,
  input  wire logic [1:0] mode,
  input  wire logic       lsb_first,
  input  wire logic [7:0] reply,
  output logic [7:0]      got
);
  int         edges = 0;
  logic       idle_v = 1'h0;
  logic [2:0] pos;

  // cpha1 moves to the next bit on every leading edge after the first
  always_comb
  begin
    pos = 3'((edges - ((mode[0] && edges > 0) ? 1 : 0)) / 2);
    miso = ss_n ? idle_v : reply[lsb_first ? pos : 3'h7 - pos];
  end

  // released line has no pull: keep it moving so stale data never passes
  always @(posedge ss_n) idle_v = ~idle_v;

  always @(negedge ss_n) edges = 0;

  always @(sclk)
  begin
    if (ss_n === 1'h0)
    begin
      if (edges % 2 == int'(mode[0]))
        got = lsb_first ? {mosi, got[7:1]} : {got[6:0], mosi};
      edges++;
    end
  end
endmodule // csm_slave_model

// ---- dv/csm_spi_engine_test.sv ----
// file: self-checking bench for the configurable spi engine
// assumes the slave model on the master link; bench plays master in slave
`timescale 1ns/1ps
module csm_spi_engine_test
  import csm_pkg::*;
;
  typedef struct packed {
    logic mv; logic [1:0] mode; logic lsb; logic [1:0] div;
    logic ro; logic irq; logic [7:0] data; logic [7:0] reply;
    logic [7:0] fill;
  } csm_row_t;

  logic       ref_clk = 1'h0;
  logic       rst_n = 1'h0;
  csm_cfg_t   cfg;
  logic       tx_valid, tx_ready, rx_valid, xfer_irq, busy;
  csm_txw_t   tx_word;
  logic [7:0] rx_data, sm_reply, sm_got;
  logic [1:0] sm_mode;
  logic       sclk_o, sclk_oe_n, mosi_o, mosi_oe_n, miso_o, miso_oe_n;
  logic       ss_n_o, ss_oe_n, tb_sclk, tb_mosi, tb_ss_n, sm_miso;
  int         err_count, samples_checked, cycles, lo, n_rx;
  wire        sclk_w = !sclk_oe_n ? sclk_o : tb_sclk;
  wire        mosi_w = !mosi_oe_n ? mosi_o : tb_mosi;
  wire        miso_w = !miso_oe_n ? miso_o : sm_miso;
  wire        ss_w   = !ss_oe_n ? ss_n_o : tb_ss_n;

  localparam csm_row_t ROWS [5] = '{
    '{1'h1, 2'h0, 1'h0, 2'h0, 1'h0, 1'h1, 8'hA5, 8'h3C, 8'h00},
    '{1'h1, 2'h1, 1'h1, 2'h1, 1'h0, 1'h0, 8'h81, 8'h7E, 8'h00},
    '{1'h1, 2'h2, 1'h0, 2'h2, 1'h1, 1'h1, 8'h12, 8'hC3, 8'hFF},
    '{1'h1, 2'h3, 1'h1, 2'h3, 1'h0, 1'h1, 8'h5A, 8'h01, 8'h00},
    '{1'h0, 2'h3, 1'h0, 2'h0, 1'h1, 1'h0, 8'h6B, 8'h96, 8'h00}};
  localparam int HALF [4] = '{2, 8, 32, 64};

  csm_spi_engine csm_spi_engine_inst (.ref_clk(ref_clk), .rst_n(rst_n),
    .cfg(cfg), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_word(tx_word), .rx_data(rx_data), .rx_valid(rx_valid),
    .xfer_irq(xfer_irq), .busy(busy), .sclk_o(sclk_o),
    .sclk_oe_n(sclk_oe_n), .sclk_i(sclk_w), .mosi_o(mosi_o),
    .mosi_oe_n(mosi_oe_n), .mosi_i(mosi_w), .miso_o(miso_o),
    .miso_oe_n(miso_oe_n), .miso_i(miso_w), .ss_n_o(ss_n_o),
    .ss_oe_n(ss_oe_n), .ss_n_i(ss_w));

  csm_slave_model csm_slave_model_inst (.sclk(sclk_w), .ss_n(ss_w),
    .mosi(mosi_w), .miso(sm_miso), .mode(sm_mode),
    .lsb_first(cfg.lsb_first), .reply(sm_reply), .got(sm_got));

  always #2 ref_clk = ~ref_clk;

  task automatic wrap_up();
    if (err_count == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // whole run is about 8000 cycles; generous ceiling
  always @(posedge ref_clk)
  begin
    cycles++;
    if (rx_valid === 1'h1)
      n_rx++;
    if (cycles == 30000)
    begin
      err_count++;
      wrap_up();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                       input string msg);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: %s saw %h want %h", $time, msg, seen,
               exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic push(input csm_txw_t w);
    tx_word = w;
    tx_valid = 1'h1;
    while (tx_ready !== 1'h1)
      step(1);
    step(1);
    tx_valid = 1'h0;
    // one edge low so a following push never re-raises in this step
    step(1);
  endtask

  // counts select-low cycles until the word completes
  task automatic wait_word();
    lo = 0;
    while (rx_valid !== 1'h1)
    begin
      if (ss_n_o === 1'h0)
        lo++;
      step(1);
    end
  endtask

  initial
  begin
    cfg = '0;
    tx_valid = 1'h0;
    tx_word = '0;
    {tb_sclk, tb_mosi, tb_ss_n} = 3'h1;
    step(12);
    check(sclk_o, 1'h0, "reset clock");
    check(ss_n_o, 1'h1, "reset select");
    check({rx_valid, busy, xfer_irq}, 3'h0, "reset flags");
    check(rx_data, 8'h00, "reset data");
    check(tx_ready, 1'h1, "reset ready");
    rst_n = 1'h1;
    foreach (ROWS[i])
    begin
      cfg = '0;
      cfg.bit_driven_variant = 1'h1;
      cfg.mode_valid = ROWS[i].mv;
      cfg.mode = ROWS[i].mode;
      cfg.lsb_first = ROWS[i].lsb;
      cfg.clock_divider_setting = ROWS[i].div;
      cfg.irq_en = ROWS[i].irq;
      cfg.read_fill_value = ROWS[i].fill;
      sm_mode = ROWS[i].mv ? ROWS[i].mode : 2'h1;
      sm_reply = ROWS[i].reply;
      step(2);
      check(sclk_o, sm_mode[1], "idle clock");
      push('{ROWS[i].ro, ROWS[i].data});
      check(busy, 1'h1, "busy");
      wait_word();
      check(16'(lo), 16'(16 * HALF[ROWS[i].div] + 1), "select time");
      check(ss_n_o, 1'h1, "select release");
      check(xfer_irq, ROWS[i].irq, "irq");
      check(rx_data, ROWS[i].reply, "read byte");
      check(sm_got, ROWS[i].ro ? ROWS[i].fill : ROWS[i].data, "sent");
      step(1);
      check(sclk_o, sm_mode[1], "clock idle after");
    end
    cfg.ss_none = 1'h1;
    push('{1'h0, 8'h5A});
    wait_word();
    check(16'(lo), 16'h0, "no select");
    check(ss_oe_n, 1'h1, "select off");
    // delays only count with an explicit mode; mode 0 adds 8 setups
    for (int t = 0; t < 2; t++)
    begin
      cfg = '0;
      cfg.bit_driven_variant = 1'h1;
      cfg.mode_valid = 1'(t == 0);
      cfg.speed_us = 8'h01;
      cfg.setup_us = 8'h01;
      sm_mode = 2'(t);
      step(2);
      push('{1'h0, 8'h3C});
      wait_word();
      check(16'(lo), t ? 16'h0021 : 16'h1771, "time");
      check(rx_data, sm_reply, "timed byte");
    end
    cfg = '0;
    cfg.bit_driven_variant = 1'h1;
    step(1);
    check({sclk_oe_n, mosi_oe_n, ss_oe_n}, 3'h0, "soft master");
    cfg = '0;
    cfg.master_en = 1'h1;
    step(1);
    check({sclk_oe_n, mosi_oe_n, ss_oe_n}, 3'h0, "hard master");
    cfg.select_suppress = 1'h1;
    step(1);
    check(ss_oe_n, 1'h1, "select suppressed");
    cfg.master_en = 1'h0;
    step(1);
    check({sclk_oe_n, mosi_oe_n}, 2'h3, "hard slave");
    cfg = '0;
    cfg.fixed_defaults = 1'h1;
    cfg.master_en = 1'h1;
    step(1);
    check({sclk_oe_n, ss_oe_n}, 2'h3, "defaults slave");
    // slave role: fifo only drains on select, so it can be filled
    cfg = '0;
    for (int i = 0; i < 16; i++)
      push('{1'h0, 8'(8'h10 + i)});
    check(tx_ready, 1'h0, "fifo full");
    n_rx = 0;
    tb_ss_n = 1'h0;
    step(4);
    check(miso_oe_n, 1'h0, "slave drives out");
    for (int b = 7; b >= 0; b--)
    begin
      tb_mosi = 1'(8'hC5 >> b);
      step(4);
      check(miso_o, 1'(8'h10 >> b), "slave out bit");
      tb_sclk = 1'h1;
      step(4);
      tb_sclk = 1'h0;
    end
    step(4);
    check(16'(n_rx), 16'h1, "slave word");
    check(rx_data, 8'hC5, "slave in byte");
    check(tx_ready, 1'h1, "fifo popped");
    // a mid-run reset must drop the words still queued
    tb_ss_n = 1'h1;
    rst_n = 1'h0;
    step(2);
    cfg.bit_driven_variant = 1'h1;
    rst_n = 1'h1;
    step(3);
    check(busy, 1'h0, "queue kept over reset");
    wrap_up();
  end
endmodule // csm_spi_engine_test
